// ### verilog/pbp_dev.sv
// pbp_dev.sv: device end of the parallel host bus port.
// assumes: core memory answers a read one cycle after mem_rd; pins are asynchronous.
`default_nettype none
`include "pbp_map.svh"

module pbp_dev
  import pbp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // host bus pins
  pbp_if.dev bus,
  // wait polarity select
  input wire logic wait_invert,
  // core memory port
  output logic mem_rd,
  output logic mem_wr,
  output pbp_addr_t mem_addr,
  output pbp_word_t mem_wdata,
  input wire pbp_word_t mem_rdata
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [`PBP_PIN_SYNC_W-1:0] pins_raw;
  logic [`PBP_PIN_SYNC_W-1:0] pins_sync;
  logic s_style;
  logic s_word;
  logic s_strb_n;
  logic s_rnw;
  logic s_oe_n;
  logic s_we_n;
  pbp_addr_t s_addr;
  pbp_word_t s_data;

  assign pins_raw = {bus.bus_style_select, bus.word_mode, bus.combined_access_strobe_n,
                     bus.read_not_write, bus.output_enable_n, bus.write_enable_n,
                     bus.addr, bus.data_bus};

  pbp_sync #(
    .W(`PBP_PIN_SYNC_W),
    .RST_VAL(`PBP_PIN_IDLE)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .pin_in(pins_raw),
    .level_out(pins_sync)
  );

  assign {s_style, s_word, s_strb_n, s_rnw, s_oe_n, s_we_n, s_addr, s_data} = pins_sync;

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic acc_rd;
  logic acc_wr;
  pbp_addr_t acc_waddr;

  // strobe style selects how read and write are qualified
  always_comb begin
    if (s_style == `PBP_STYLE_SPLIT) begin
      acc_rd = !s_oe_n;
      acc_wr = !s_we_n;
    end else begin
      acc_rd = !s_strb_n && (s_rnw == `PBP_DIR_READ);
      acc_wr = !s_strb_n && (s_rnw == `PBP_DIR_WRITE);
    end
  end

  // word address of the pin address, byte mode drops the byte select
  assign acc_waddr = s_word ? s_addr : {1'b0, s_addr[`PBP_ADDR_W-1:1]};

  // picks the byte or word presented on the bus
  function automatic pbp_word_t pick(input pbp_word_t w, input logic word, input logic hi);
    pbp_word_t r;
    r = w;
    if (!word) begin
      r = hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    end
    return r;
  endfunction : pick

  // ****************************************************************
  // state and registers
  // ****************************************************************
  pbp_dev_state_t state_reg;
  pbp_word_t buf_reg;
  pbp_addr_t buf_waddr_reg;
  logic buf_valid_reg;
  pbp_addr_t exp_addr_reg;
  logic exp_valid_reg;
  pbp_addr_t cur_addr_reg;
  pbp_addr_t fetch_waddr_reg;
  logic wait_act_reg;
  logic wait_pin_reg;
  pbp_word_t dout_reg;
  logic dout_oe_reg;
  logic mem_rd_reg;
  logic wr_prev_reg;
  logic wr_commit;
  logic seq_hit;
  pbp_addr_t next_addr;
  pbp_addr_t next_waddr;

  // read at the expected address with its word already buffered
  assign seq_hit = exp_valid_reg && (s_addr == exp_addr_reg) && buf_valid_reg &&
                   (buf_waddr_reg == acc_waddr);
  assign next_addr = cur_addr_reg + 16'h0001;
  assign next_waddr = s_word ? next_addr : {1'b0, next_addr[`PBP_ADDR_W-1:1]};

  // ****************************************************************
  // read state machine
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= PBP_D_IDLE;
      cur_addr_reg <= `PBP_RST_WORD;
      fetch_waddr_reg <= `PBP_RST_WORD;
      wait_act_reg <= 1'b0;
      dout_reg <= `PBP_RST_WORD;
      dout_oe_reg <= 1'b0;
      mem_rd_reg <= 1'b0;
    end else begin
      mem_rd_reg <= 1'b0;
      case (state_reg)
        PBP_D_IDLE: begin
          if (acc_rd) begin
            cur_addr_reg <= s_addr;
            if (seq_hit) begin
              // served from the prefetch buffer at once, no wait
              dout_reg <= pick(buf_reg, s_word, s_addr[`PBP_BYTE_SEL_BIT]);
              dout_oe_reg <= 1'b1;
              wait_act_reg <= 1'b0;
              state_reg <= PBP_D_HOLD;
            end else begin
              // first or non-sequential read: fetch under wait
              fetch_waddr_reg <= acc_waddr;
              mem_rd_reg <= 1'b1;
              wait_act_reg <= 1'b1;
              state_reg <= PBP_D_FETCH;
            end
          end
        end
        PBP_D_FETCH: begin
          state_reg <= PBP_D_GRAB;
        end
        PBP_D_GRAB: begin
          // data and wait release change on the same edge
          dout_reg <= pick(mem_rdata, s_word, cur_addr_reg[`PBP_BYTE_SEL_BIT]);
          dout_oe_reg <= 1'b1;
          wait_act_reg <= 1'b0;
          state_reg <= PBP_D_HOLD;
        end
        PBP_D_HOLD: begin
          if (!acc_rd) begin
            dout_oe_reg <= 1'b0;
            if (!(buf_valid_reg && buf_waddr_reg == next_waddr)) begin
              fetch_waddr_reg <= next_waddr;
              mem_rd_reg <= 1'b1;
              state_reg <= PBP_D_PREF;
            end else begin
              state_reg <= PBP_D_IDLE;
            end
          end
        end
        PBP_D_PREF: begin
          state_reg <= PBP_D_PGRAB;
        end
        PBP_D_PGRAB: begin
          state_reg <= PBP_D_IDLE;
        end
        default: begin
          state_reg <= PBP_D_IDLE;
          dout_oe_reg <= 1'b0;
          wait_act_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // prefetch buffer and expected address
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buf_reg <= `PBP_RST_WORD;
      buf_waddr_reg <= `PBP_RST_WORD;
      buf_valid_reg <= 1'b0;
    end else if (wr_commit) begin
      buf_valid_reg <= 1'b0; // a write may stale the buffered word
    end else if (state_reg == PBP_D_GRAB || state_reg == PBP_D_PGRAB) begin
      buf_reg <= mem_rdata;
      buf_waddr_reg <= fetch_waddr_reg;
      buf_valid_reg <= 1'b1;
    end
  end

  // next read is sequential only at the served address plus one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exp_addr_reg <= `PBP_RST_WORD;
      exp_valid_reg <= 1'b0;
    end else if (wr_commit) begin
      exp_valid_reg <= 1'b0;
    end else if (state_reg == PBP_D_HOLD && !acc_rd) begin
      exp_addr_reg <= next_addr;
      exp_valid_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // write path
  // ****************************************************************
  pbp_word_t wlat_data_reg;
  pbp_addr_t wlat_addr_reg;
  logic [7:0] lo_byte_reg;
  pbp_addr_t lo_waddr_reg;
  logic lo_valid_reg;
  logic mem_wr_reg;
  pbp_addr_t mem_addr_reg;
  pbp_word_t mem_wdata_reg;
  pbp_addr_t wlat_waddr;

  // write completes on the strobe's trailing edge
  assign wr_commit = wr_prev_reg && !acc_wr;
  assign wlat_waddr = {1'b0, wlat_addr_reg[`PBP_ADDR_W-1:1]};

  // latch address and data while the write strobe stands
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_prev_reg <= 1'b0;
      wlat_data_reg <= `PBP_RST_WORD;
      wlat_addr_reg <= `PBP_RST_WORD;
    end else begin
      wr_prev_reg <= acc_wr;
      if (acc_wr) begin
        wlat_data_reg <= s_data;
        wlat_addr_reg <= s_addr;
      end
    end
  end

  // commit a word cycle as it ends; a low byte cycle is held and written with its high byte
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= `PBP_RST_WORD;
      mem_wdata_reg <= `PBP_RST_WORD;
      lo_byte_reg <= 8'h00;
      lo_waddr_reg <= `PBP_RST_WORD;
      lo_valid_reg <= 1'b0;
    end else begin
      mem_wr_reg <= 1'b0;
      // fetch address loads on the edge that raises mem_rd
      if (state_reg == PBP_D_IDLE && acc_rd && !seq_hit) begin
        mem_addr_reg <= acc_waddr;
      end else if (state_reg == PBP_D_HOLD && !acc_rd &&
                   !(buf_valid_reg && buf_waddr_reg == next_waddr)) begin
        mem_addr_reg <= next_waddr;
      end
      if (wr_commit) begin
        if (s_word) begin
          mem_wr_reg <= 1'b1;
          mem_addr_reg <= wlat_addr_reg;
          mem_wdata_reg <= wlat_data_reg;
        end else if (!wlat_addr_reg[`PBP_BYTE_SEL_BIT]) begin
          lo_byte_reg <= wlat_data_reg[7:0];
          lo_waddr_reg <= wlat_waddr;
          lo_valid_reg <= 1'b1;
        end else begin
          lo_valid_reg <= 1'b0;
          if (lo_valid_reg && lo_waddr_reg == wlat_waddr) begin
            mem_wr_reg <= 1'b1;
            mem_addr_reg <= wlat_waddr;
            mem_wdata_reg <= {wlat_data_reg[7:0], lo_byte_reg};
          end
        end
      end
    end
  end

  // ****************************************************************
  // wait pin with selectable sense
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_pin_reg <= 1'b0;
    end else begin
      wait_pin_reg <= ((state_reg == PBP_D_IDLE && acc_rd && !seq_hit) || (wait_act_reg &&
                       state_reg != PBP_D_GRAB)) ^ wait_invert;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus.dev_data = dout_reg;
  assign bus.dev_data_oe = dout_oe_reg;
  assign bus.wait_pin = wait_pin_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;

endmodule : pbp_dev

`default_nettype wire

// ### verilog/pbp_map.svh
// pbp_map.svh: constants shared by both ends of the parallel host bus port.
// assumes: included by bare name from package and modules; holds defines only.
`ifndef PBP_MAP_SVH
`define PBP_MAP_SVH

// ****************************************************************
// bus encodings
// ****************************************************************
`define PBP_STYLE_COMBINED 1'b0
`define PBP_STYLE_SPLIT 1'b1
`define PBP_DIR_READ 1'b1
`define PBP_DIR_WRITE 1'b0

// ****************************************************************
// widths and field positions
// ****************************************************************
`define PBP_ADDR_W 16
`define PBP_DATA_W 16
`define PBP_BYTE_SEL_BIT 0
`define PBP_PIN_SYNC_W 38

// ****************************************************************
// host timing counts, in 50 ns clock cycles
// ****************************************************************
`define PBP_HOST_SETUP_CYC 4'd2
`define PBP_HOST_STROBE_MIN_CYC 4'd12
`define PBP_HOST_INACT_CYC 4'd4

// ****************************************************************
// reset values
// ****************************************************************
`define PBP_RST_WORD 16'h0000
`define PBP_RST_STATE 3'h0
// idle pin levels: style 0, word mode, all strobes high, read, addr and data 0
`define PBP_PIN_IDLE 38'h1f_0000_0000

`endif

// ### verilog/pbp_pkg.sv
// pbp_pkg.sv: types of the parallel host bus port.
// assumes: pbp_map.svh is on the include path.
`default_nettype none
`include "pbp_map.svh"

package pbp_pkg;

  typedef logic [`PBP_ADDR_W-1:0] pbp_addr_t;
  typedef logic [`PBP_DATA_W-1:0] pbp_word_t;

  // device states, gray along idle-fetch-grab-hold-prefetch-capture
  typedef enum logic [2:0] {
    PBP_D_IDLE = 3'h0,
    PBP_D_FETCH = 3'h1,
    PBP_D_GRAB = 3'h3,
    PBP_D_HOLD = 3'h2,
    PBP_D_PREF = 3'h6,
    PBP_D_PGRAB = 3'h7
  } pbp_dev_state_t;

  // host states, gray along idle-setup-strobe-recover
  typedef enum logic [1:0] {
    PBP_H_IDLE = 2'h0,
    PBP_H_SETUP = 2'h1,
    PBP_H_STROBE = 2'h3,
    PBP_H_RECOV = 2'h2
  } pbp_host_state_t;

endpackage : pbp_pkg

`default_nettype wire

// ### verilog/pbp_if.sv
// pbp_if.sv: pins between the host end and the device end.
// assumes: both ends on one clock; data bus level resolved here from the enables.
`default_nettype none

interface pbp_if;
  import pbp_pkg::*;

  // mode pins, driven by the host side
  logic bus_style_select;
  logic word_mode;
  // strobes and direction, all active low except direction
  logic combined_access_strobe_n;
  logic read_not_write;
  logic output_enable_n;
  logic write_enable_n;
  pbp_addr_t addr;
  // two-way data bus as separate drives
  pbp_word_t host_data;
  logic host_data_oe;
  pbp_word_t dev_data;
  logic dev_data_oe;
  pbp_word_t data_bus;
  // wait, polarity set inside the device
  logic wait_pin;

  // bus level: whoever enables drives, else floats low
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

  modport dev (
    input bus_style_select, word_mode, combined_access_strobe_n, read_not_write,
    input output_enable_n, write_enable_n, addr, data_bus,
    output dev_data, dev_data_oe, wait_pin
  );

  modport host (
    output bus_style_select, word_mode, combined_access_strobe_n, read_not_write,
    output output_enable_n, write_enable_n, addr, host_data, host_data_oe,
    input data_bus, wait_pin
  );

endinterface : pbp_if

`default_nettype wire

// ### verilog/pbp_sync.sv
// pbp_sync.sv: three-stage pin synchroniser with agreement filter.
// assumes: inputs come from another domain; out changes once stages two and three agree.
`default_nettype none

module pbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pins in, filtered level out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  // ****************************************************************
  // one filtered stage per bit
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      // first stage feeds only the second; reset to the pin's idle level
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          s1_reg <= RST_VAL[i];
          s2_reg <= RST_VAL[i];
          s3_reg <= RST_VAL[i];
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // accept a change only when the last two stages agree
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          lvl_reg <= RST_VAL[i]; // no false edge after reset
        end else if (s2_reg == s3_reg) begin
          lvl_reg <= s3_reg;
        end
      end
      assign level_out[i] = lvl_reg;
    end
  endgenerate

endmodule : pbp_sync

`default_nettype wire

// ### verilog/pbp_host.sv
// pbp_host.sv: host end of the parallel host bus port.
// assumes: user issues word commands; device pins are asynchronous to this clock.
`default_nettype none
`include "pbp_map.svh"

module pbp_host
  import pbp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // host bus pins
  pbp_if.host bus,
  // mode selection
  input wire logic style_sel,
  input wire logic word_sel,
  input wire logic wait_invert,
  // word command and answer
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire pbp_addr_t cmd_addr,
  input wire pbp_word_t cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output pbp_word_t rsp_rdata
);

  // ****************************************************************
  // pin synchronisation of wait and data
  // ****************************************************************
  logic [16:0] s_pins;
  logic wait_seen;

  pbp_sync #(
    .W(17)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .pin_in({bus.wait_pin, bus.data_bus}),
    .level_out(s_pins)
  );

  assign wait_seen = s_pins[16] ^ wait_invert;

  // ****************************************************************
  // registers
  // ****************************************************************
  pbp_host_state_t state_reg;
  logic [3:0] cnt_reg;
  logic beat_reg;
  logic write_reg;
  logic word_reg;
  logic style_reg;
  pbp_addr_t addr_reg;
  pbp_word_t wdata_reg;
  pbp_word_t rdata_reg;
  logic ready_reg;
  logic rsp_reg;
  logic strb_n_reg;
  logic rnw_reg;
  logic oe_n_reg;
  logic we_n_reg;
  pbp_addr_t pin_addr_reg;
  pbp_word_t pin_data_reg;
  logic pin_data_oe_reg;

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= PBP_H_IDLE;
      cnt_reg <= 4'h0;
      beat_reg <= 1'b0;
      write_reg <= 1'b0;
      word_reg <= 1'b1;
      style_reg <= 1'b0;
      addr_reg <= `PBP_RST_WORD;
      wdata_reg <= `PBP_RST_WORD;
      rdata_reg <= `PBP_RST_WORD;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      strb_n_reg <= 1'b1;
      rnw_reg <= `PBP_DIR_READ;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      pin_addr_reg <= `PBP_RST_WORD;
      pin_data_reg <= `PBP_RST_WORD;
      pin_data_oe_reg <= 1'b0;
    end else begin
      rsp_reg <= 1'b0;
      case (state_reg)
        PBP_H_IDLE: begin
          ready_reg <= 1'b1;
          style_reg <= style_sel;
          word_reg <= word_sel;
          if (cmd_valid && ready_reg) begin
            ready_reg <= 1'b0;
            write_reg <= cmd_write;
            addr_reg <= cmd_addr;
            wdata_reg <= cmd_wdata;
            beat_reg <= 1'b0;
            // word mode one cycle, byte mode low byte first
            pin_addr_reg <= word_reg ? cmd_addr : {cmd_addr[14:0], 1'b0};
            pin_data_reg <= word_reg ? cmd_wdata : {8'h00, cmd_wdata[7:0]};
            pin_data_oe_reg <= cmd_write;
            rnw_reg <= cmd_write ? `PBP_DIR_WRITE : `PBP_DIR_READ;
            cnt_reg <= 4'h0;
            state_reg <= PBP_H_SETUP;
          end
        end
        PBP_H_SETUP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 >= `PBP_HOST_SETUP_CYC) begin
            cnt_reg <= 4'h0;
            if (style_reg == `PBP_STYLE_SPLIT) begin
              oe_n_reg <= write_reg;
              we_n_reg <= !write_reg;
            end else begin
              strb_n_reg <= 1'b0;
            end
            state_reg <= PBP_H_STROBE;
          end
        end
        PBP_H_STROBE: begin
          if (cnt_reg < `PBP_HOST_STROBE_MIN_CYC) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          // reads stay stretched while wait is seen
          if (cnt_reg >= `PBP_HOST_STROBE_MIN_CYC && (write_reg || !wait_seen)) begin
            if (!write_reg) begin
              if (word_reg) begin
                rdata_reg <= s_pins[15:0];
              end else if (beat_reg) begin
                rdata_reg[15:8] <= s_pins[7:0];
              end else begin
                rdata_reg[7:0] <= s_pins[7:0];
              end
            end
            strb_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= PBP_H_RECOV;
          end
        end
        PBP_H_RECOV: begin
          pin_data_oe_reg <= 1'b0;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg + 4'h1 >= `PBP_HOST_INACT_CYC) begin
            cnt_reg <= 4'h0;
            if (!word_reg && !beat_reg) begin
              // second byte at the next sequential byte address
              beat_reg <= 1'b1;
              pin_addr_reg <= {addr_reg[14:0], 1'b1};
              pin_data_reg <= {8'h00, wdata_reg[15:8]};
              pin_data_oe_reg <= write_reg;
              state_reg <= PBP_H_SETUP;
            end else begin
              rsp_reg <= 1'b1;
              state_reg <= PBP_H_IDLE;
            end
          end
        end
        default: begin
          state_reg <= PBP_H_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign bus.bus_style_select = style_reg;
  assign bus.word_mode = word_reg;
  assign bus.combined_access_strobe_n = strb_n_reg;
  assign bus.read_not_write = rnw_reg;
  assign bus.output_enable_n = oe_n_reg;
  assign bus.write_enable_n = we_n_reg;
  assign bus.addr = pin_addr_reg;
  assign bus.host_data = pin_data_reg;
  assign bus.host_data_oe = pin_data_oe_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;

endmodule : pbp_host

`default_nettype wire

// ### tb/pbp_assertions.sv
// pbp_assertions.sv: checker on the pins between host end and device end.
// assumes: instanced beside the interface; one clock, reset active high.
`default_nettype none

module pbp_assertions
  import pbp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus pins and wait sense
  input wire logic bus_style_select,
  input wire logic word_mode,
  input wire logic combined_access_strobe_n,
  input wire logic read_not_write,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire pbp_word_t dev_data,
  input wire logic wait_pin,
  input wire logic wait_invert
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // decoded qualifiers and properties
  // ****************************************************************
  wire logic rd_q = bus_style_select ? !output_enable_n
                                     : !combined_access_strobe_n && read_not_write;
  wire logic wr_q = bus_style_select ? !write_enable_n
                                     : !combined_access_strobe_n && !read_not_write;
  wire logic wait_act = wait_pin != wait_invert;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // wait drops as data is driven, a few cycles on
  sequence s_release;
    ##[1:4] (!wait_act && dev_data_oe);
  endsequence
  property p_style0; !bus_style_select |-> output_enable_n && write_enable_n; endproperty
  property p_style1; bus_style_select |-> combined_access_strobe_n; endproperty
  property p_byte_hi; !word_mode && dev_data_oe |-> dev_data[15:8] == 8'h00; endproperty
  property p_write_drive; wr_q |-> host_data_oe && !dev_data_oe; endproperty
  property p_wait_read;
    wait_act && !$past(reset) && $stable(wait_invert) |-> rd_q && !dev_data_oe;
  endproperty
  property p_wait_bound;
    $rose(wait_act) && !$past(reset) && $stable(wait_invert) |-> s_release;
  endproperty
  property p_wait_hold;
    wait_act && !$past(reset) && $stable(wait_invert) |=> rd_q;
  endproperty
  property p_polarity;
    !rd_q && !$past(rd_q) && !$past(reset) && $stable(wait_invert) |-> wait_pin == wait_invert;
  endproperty
  a_style0: assert property (p_style0) else $error("style 0 used a split strobe");
  a_style1: assert property (p_style1) else $error("style 1 used the combined strobe");
  a_byte_hi: assert property (p_byte_hi) else $error("byte read upper half not zero");
  a_write_drive: assert property (p_write_drive) else $error("write without host drive");
  a_wait_read: assert property (p_wait_read) else $error("wait outside a read");
  a_wait_bound: assert property (p_wait_bound) else $error("wait not released");
  a_wait_hold: assert property (p_wait_hold) else $error("read ended under wait");
  a_polarity: assert property (p_polarity) else $error("idle wait level wrong");
endmodule : pbp_assertions

`default_nettype wire

// ### tb/testbench.sv
// testbench.sv: host end and device end joined, word commands in, memory model.
// assumes: design sources compiled first; 50 ns clock.
`default_nettype none

module testbench
  import pbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals, instances and tasks
  // ****************************************************************
  logic clock = 1'b0, reset = 1'b1, style_sel = 1'b0, word_sel = 1'b1, wait_invert = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid, mem_rd, mem_wr;
  pbp_addr_t cmd_addr = 16'h0000, mem_addr;
  pbp_word_t cmd_wdata = 16'h0000, mem_rdata = 16'h0000, rsp_rdata, mem_wdata, got, d0;
  pbp_word_t mem [256];
  int fail_count = 0, n_compared = 0, waits;

  always #25 clock = ~clock;
  pbp_if bus_if ();
  pbp_host u_pbp_host (.clock, .reset, .bus(bus_if.host), .style_sel, .word_sel,
    .wait_invert, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid,
    .rsp_rdata);
  pbp_dev u_pbp_dev (.clock, .reset, .bus(bus_if.dev), .wait_invert, .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata);
  pbp_assertions u_pbp_assertions (.clock, .reset, .wait_invert,
    .bus_style_select(bus_if.bus_style_select), .word_mode(bus_if.word_mode),
    .combined_access_strobe_n(bus_if.combined_access_strobe_n),
    .read_not_write(bus_if.read_not_write), .output_enable_n(bus_if.output_enable_n),
    .write_enable_n(bus_if.write_enable_n), .host_data_oe(bus_if.host_data_oe),
    .dev_data_oe(bus_if.dev_data_oe), .dev_data(bus_if.dev_data), .wait_pin(bus_if.wait_pin));

  // core memory, read data the cycle after mem_rd
  always @(posedge clock) begin
    if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr[7:0]];
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // a used-up bound ends the run
  task automatic guard(input int n);
    if (n >= 400) begin
      check("timeout", 16'h0000, 16'h0001);
      results();
    end
  endtask : guard

  // one word command, counting wait cycles until the answer
  task automatic cmd(input logic w, input pbp_addr_t a, input pbp_word_t d);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge clock);
    guard(n);
    @(negedge clock);
    cmd_valid = 1'b0;
    waits = 0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++) begin
      if (wait_pin_seen()) waits++;
      @(negedge clock);
    end
    guard(n);
    got = rsp_rdata;
  endtask : cmd

  function automatic logic wait_pin_seen();
    return bus_if.wait_pin !== wait_invert;
  endfunction : wait_pin_seen

  // every style, width and wait sense in turn
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    repeat (6) @(negedge clock);
    for (int c = 0; c < 8; c++) begin
      style_sel = c[0];
      word_sel = c[1];
      wait_invert = c[2];
      d0 = 16'h1234 + 16'(c) * 16'h0101;
      cmd(1'b1, 16'(8 * c), d0);
      cmd(1'b1, 16'(8 * c + 1), ~d0);
      // device commits after its filtered strobe edge, later than the answer
      repeat (4) @(negedge clock);
      check("mem low word", mem[8 * c], d0);
      check("mem next word", mem[8 * c + 1], ~d0);
      cmd(1'b0, 16'(8 * c), 16'h0000);
      check("first read", got, d0);
      check("first wait", 16'(waits > 0), 16'h0001);
      cmd(1'b0, 16'(8 * c + 1), 16'h0000);
      check("next read", got, ~d0);
      check("next wait", 16'(waits), 16'h0000);
      cmd(1'b0, 16'(8 * c), 16'h0000);
      check("jump read", got, d0);
      check("jump wait", 16'(waits > 0), 16'h0001);
      $display("test %0d done", c);
    end
    results();
  end
endmodule : testbench

`default_nettype wire
